// *** lcdc_pkg.sv ***
// Package for the segment LCD command decoder and display controller.
// Assumes a byte-wide receive front end that delivers bytes after address match.
package lcdc_pkg;

  // Opcode patterns and masks
  localparam logic [7:0] LCDC_MODE_MASK  = 8'hf0;
  localparam logic [7:0] LCDC_MODE_PAT   = 8'hc0;
  localparam logic [7:0] LCDC_PTR_MASK   = 8'h80;
  localparam logic [7:0] LCDC_PTR_PAT    = 8'h00;
  localparam logic [7:0] LCDC_SUB_MASK   = 8'hf8;
  localparam logic [7:0] LCDC_SUB_PAT    = 8'he0;
  localparam logic [7:0] LCDC_BANK_MASK  = 8'hfc;
  localparam logic [7:0] LCDC_BANK_PAT   = 8'hf8;
  localparam logic [7:0] LCDC_BLINK_MASK = 8'hf8;
  localparam logic [7:0] LCDC_BLINK_PAT  = 8'hf0;

  // Field positions
  localparam int LCDC_ENA_BIT    = 3;
  localparam int LCDC_BIAS_BIT   = 2;
  localparam int LCDC_IBANK_BIT  = 1;
  localparam int LCDC_OBANK_BIT  = 0;
  localparam int LCDC_BMODE_BIT  = 2;
  localparam int LCDC_CONT_BIT   = 7;
  localparam int LCDC_ROUTE_BIT  = 6;

  // Display RAM size
  localparam int         LCDC_RAM_DEPTH = 80;
  localparam logic [6:0] LCDC_PTR_LAST  = 7'h4f;

  // Drive mode codes
  localparam logic [1:0] LCDC_DRV_STATIC = 2'h1;
  localparam logic [1:0] LCDC_DRV_MUX2   = 2'h2;
  localparam logic [1:0] LCDC_DRV_MUX3   = 2'h3;
  localparam logic [1:0] LCDC_DRV_MUX4   = 2'h0;

  // Reset values
  localparam logic [1:0] LCDC_RST_DRIVE = 2'h1;
  localparam logic [1:0] LCDC_RST_RATE  = 2'h0;

  // Blink periods in display clock ticks (divide by 768, 1536, 3072)
  localparam logic [11:0] LCDC_BLINK_DIV1 = 12'h300;
  localparam logic [11:0] LCDC_BLINK_DIV2 = 12'h600;
  localparam logic [11:0] LCDC_BLINK_DIV3 = 12'hc00;

  // Command classes
  typedef enum logic [2:0] {
    LCDC_CMD_NONE,
    LCDC_CMD_MODE,
    LCDC_CMD_PTR,
    LCDC_CMD_SUB,
    LCDC_CMD_BANK,
    LCDC_CMD_BLINK
  } lcdc_cmd_t;

  // Byte stream context
  typedef enum logic [1:0] {
    LCDC_CTX_CTRL,
    LCDC_CTX_CMD,
    LCDC_CTX_DATA
  } lcdc_ctx_t;

endpackage

// *** lcdc_classify.sv ***
// Opcode classifier for command bytes.
// Purely combinational; the caller qualifies with its own strobe.
`timescale 1ns/1ps
module lcdc_classify (
  // Command byte in
  input  wire logic [7:0]         cmd_byte,
  // Decoded class out
  output lcdc_pkg::lcdc_cmd_t     cmd_class
);
  import lcdc_pkg::*;

  // Fixed high-order patterns, least specific (pointer, bit 7 only) first
  always_comb begin
    if ((cmd_byte & LCDC_PTR_MASK) == LCDC_PTR_PAT) begin
      cmd_class = LCDC_CMD_PTR;
    end else if ((cmd_byte & LCDC_MODE_MASK) == LCDC_MODE_PAT) begin
      cmd_class = LCDC_CMD_MODE;
    end else if ((cmd_byte & LCDC_SUB_MASK) == LCDC_SUB_PAT) begin
      cmd_class = LCDC_CMD_SUB;
    end else if ((cmd_byte & LCDC_BANK_MASK) == LCDC_BANK_PAT) begin
      // Bits 1 and 0 carry the input and output bank, so neither is part of the pattern
      cmd_class = LCDC_CMD_BANK;
    end else if ((cmd_byte & LCDC_BLINK_MASK) == LCDC_BLINK_PAT) begin
      cmd_class = LCDC_CMD_BLINK;
    end else begin
      cmd_class = LCDC_CMD_NONE;
    end
  end

endmodule

// *** lcdc_ctrl.sv ***
// Command decoder and display controller for a segment LCD driver.
// Assumes a serial slave front end that strobes each received byte after
// address match and pulses frame_start at every start condition.
// How it works
// - Classify command bytes by opcode high bits
// - Mode-set loads drive mode and bias
// - Mode-set bit 3 blanks or enables display
// - Bit7 zero loads seven-bit data pointer
// - Pattern 11100 loads subaddress counter
// - Bank-select bit 1 picks input bank
// - Bank-select bit 0 picks output bank
// - Bank-select ignored in three/four backplane modes
// - Blink-select bit 2 picks blink mode
// - Blink-select low bits set blink rate
// - Execute commands, store display bytes in order
// - Control byte: continue bit and route bit
// - Advance pointer after each data byte, carrying into subaddress
// - Bank-alternation blink swaps output bank automatically
`timescale 1ns/1ps
module lcdc_ctrl #(
  parameter int RAM_DEPTH = lcdc_pkg::LCDC_RAM_DEPTH
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Received byte stream
  input  wire logic        frame_start,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  // Hardware subaddress straps
  input  wire logic [2:0]  hw_subaddr,
  // Display clock tick (one pulse per display clock period)
  input  wire logic        disp_tick,
  // Display RAM read port for the waveform generator
  input  wire logic [6:0]  ram_rd_addr,
  output logic      [3:0]  ram_rd_data,
  // Control state out
  output logic             display_enable,
  output logic             bias_half,
  output logic      [1:0]  drive_mode,
  output logic      [6:0]  data_pointer,
  output logic      [2:0]  subaddr_count,
  output logic             input_bank,
  output logic             output_bank,
  output logic             blink_alt_mode,
  output logic      [1:0]  blink_rate_field,
  output logic             display_bank,
  output logic             blink_phase,
  // Stream context flags
  output logic             continuation_flag,
  output logic             register_route_flag
);
  import lcdc_pkg::*;

  // Decoded class of the current byte
  lcdc_cmd_t cmd_class;

  // Stream context and control state
  lcdc_ctx_t   ctx_q,    ctx_d;       // What the next byte is
  logic        cont_q,   cont_d;      // Latched continue bit
  logic        route_q,  route_d;     // Latched route bit
  logic        ena_q,    ena_d;       // Display enable
  logic        bias_q,   bias_d;      // Half bias when set
  logic [1:0]  drv_q,    drv_d;       // Drive mode code
  logic [6:0]  ptr_q,    ptr_d;       // Data pointer
  logic [2:0]  sub_q,    sub_d;       // Subaddress counter
  logic        ibank_q,  ibank_d;     // Input bank
  logic        obank_q,  obank_d;     // Output bank
  logic        bmode_q,  bmode_d;     // Bank-alternation blink
  logic [1:0]  rate_q,   rate_d;      // Blink rate

  // Blink timer state
  logic [11:0] bcnt_q,   bcnt_d;      // Display tick counter
  logic        bph_q,    bph_d;       // Blink phase
  logic [11:0] bdiv;                  // Selected half period

  // Display RAM write path
  logic [3:0]  ram_q [RAM_DEPTH];     // 80 x 4 display memory
  logic        wr_en;                 // Store this byte
  logic [6:0]  wr_addr;               // Address being written
  logic [3:0]  wr_mask;               // Bits written
  logic [3:0]  wr_val;                // Values written
  logic        sub_match;             // This device selected
  logic        store_byte;            // Data byte in data context
  logic        cmd_byte;              // Command byte in command context

  // Opcode classifier
  lcdc_classify u_classify (
    .cmd_byte  (byte_data),
    .cmd_class (cmd_class)
  );

  assign cmd_byte   = byte_valid && ctx_q == LCDC_CTX_CMD;
  assign store_byte = byte_valid && ctx_q == LCDC_CTX_DATA;
  assign sub_match  = sub_q == hw_subaddr;

  // Next control state from the byte stream
  always_comb begin
    ctx_d        = ctx_q;
    cont_d       = cont_q;
    route_d      = route_q;
    ena_d        = ena_q;
    bias_d       = bias_q;
    drv_d        = drv_q;
    ptr_d        = ptr_q;
    sub_d        = sub_q;
    ibank_d      = ibank_q;
    obank_d      = obank_q;
    bmode_d      = bmode_q;
    rate_d       = rate_q;
    if (frame_start) begin
      // New transfer opens with a control byte
      ctx_d = LCDC_CTX_CTRL;
    end else if (byte_valid) begin
      case (ctx_q)
        LCDC_CTX_CTRL: begin
          cont_d  = byte_data[LCDC_CONT_BIT];
          route_d = byte_data[LCDC_ROUTE_BIT];
          ctx_d   = byte_data[LCDC_ROUTE_BIT] ? LCDC_CTX_DATA
                                               : LCDC_CTX_CMD;
        end
        LCDC_CTX_CMD: begin
          // Continue bit set: one byte then another control byte
          if (cont_q) begin
            ctx_d = LCDC_CTX_CTRL;
          end
          case (cmd_class)
            LCDC_CMD_MODE: begin
              ena_d  = byte_data[LCDC_ENA_BIT];
              bias_d = byte_data[LCDC_BIAS_BIT];
              drv_d  = byte_data[1:0];
            end
            LCDC_CMD_PTR: begin
              ptr_d        = byte_data[6:0];
            end
            LCDC_CMD_SUB: begin
              sub_d = byte_data[2:0];
            end
            LCDC_CMD_BANK: begin
              // Only static and mux2 have alternate banks
              if (drv_q == LCDC_DRV_STATIC || drv_q == LCDC_DRV_MUX2) begin
                ibank_d = byte_data[LCDC_IBANK_BIT];
                obank_d = byte_data[LCDC_OBANK_BIT];
              end
            end
            LCDC_CMD_BLINK: begin
              bmode_d = byte_data[LCDC_BMODE_BIT];
              rate_d  = byte_data[1:0];
            end
            default: begin
              // Unmatched opcode: nothing changes
            end
          endcase
        end
        LCDC_CTX_DATA: begin
          if (cont_q) begin
            ctx_d = LCDC_CTX_CTRL;
          end
          // Skipped writes (pointer above 79, other subaddress) still advance
          // Advance after each stored byte, carrying into subaddress
          if (ptr_q == LCDC_PTR_LAST) begin
            ptr_d = 7'h00;
            sub_d = sub_q + 3'h1;
          end else begin
            ptr_d = ptr_q + 7'h01;
          end
        end
        default: begin
          ctx_d = LCDC_CTX_CTRL;
        end
      endcase
    end
  end

  // Control state registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctx_q        <= LCDC_CTX_CTRL;
      cont_q       <= 1'b0;
      route_q      <= 1'b0;
      ena_q        <= 1'b0;
      bias_q       <= 1'b0;
      drv_q        <= LCDC_RST_DRIVE;
      ptr_q        <= 7'h00;
      sub_q        <= 3'h0;
      ibank_q      <= 1'b0;
      obank_q      <= 1'b0;
      bmode_q      <= 1'b0;
      rate_q       <= LCDC_RST_RATE;
    end else begin
      ctx_q        <= ctx_d;
      cont_q       <= cont_d;
      route_q      <= route_d;
      ena_q        <= ena_d;
      bias_q       <= bias_d;
      drv_q        <= drv_d;
      ptr_q        <= ptr_d;
      sub_q        <= sub_d;
      ibank_q      <= ibank_d;
      obank_q      <= obank_d;
      bmode_q      <= bmode_d;
      rate_q       <= rate_d;
    end
  end

  // Blink half period from the rate setting
  always_comb begin
    case (rate_q)
      2'h1:    bdiv = LCDC_BLINK_DIV1 >> 1;
      2'h2:    bdiv = LCDC_BLINK_DIV2 >> 1;
      2'h3:    bdiv = LCDC_BLINK_DIV3 >> 1;
      default: bdiv = 12'h000;
    endcase
  end

  // Blink timer next state
  always_comb begin
    bcnt_d = bcnt_q;
    bph_d  = bph_q;
    if (rate_q == 2'h0) begin
      // Blinking off: park the timer
      bcnt_d = 12'h000;
      bph_d  = 1'b0;
    end else if (disp_tick) begin
      if (bcnt_q >= bdiv - 12'h001) begin
        bcnt_d = 12'h000;
        bph_d  = !bph_q;
      end else begin
        bcnt_d = bcnt_q + 12'h001;
      end
    end
  end

  // Blink timer registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bcnt_q <= 12'h000;
      bph_q  <= 1'b0;
    end else begin
      bcnt_q <= bcnt_d;
      bph_q  <= bph_d;
    end
  end

  // Write mask from drive mode and input bank
  always_comb begin
    wr_addr = ptr_q;
    wr_mask = 4'h0;
    wr_val  = 4'h0;
    wr_en   = store_byte && sub_match && ptr_q <= LCDC_PTR_LAST;
    case (drv_q)
      LCDC_DRV_STATIC: begin
        wr_mask = ibank_q ? 4'h4 : 4'h1;
        wr_val  = {1'b0, byte_data[7], 1'b0, byte_data[7]};
      end
      LCDC_DRV_MUX2: begin
        wr_mask = ibank_q ? 4'hc : 4'h3;
        wr_val  = {byte_data[7:6], byte_data[7:6]};
      end
      LCDC_DRV_MUX3: begin
        wr_mask = 4'h7;
        wr_val  = {1'b0, byte_data[7:5]};
      end
      default: begin
        wr_mask = 4'hf;
        wr_val  = byte_data[7:4];
      end
    endcase
  end

  // Display RAM store, one location per data byte
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      ram_q[wr_addr] <= (ram_q[wr_addr] & ~wr_mask) | (wr_val & wr_mask);
    end
  end

  // Registered read for the waveform generator
  // Out-of-range reads return zero, never an undefined word
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ram_rd_data <= 4'h0;
    end else if (ram_rd_addr <= LCDC_PTR_LAST) begin
      ram_rd_data <= ram_q[ram_rd_addr];
    end else begin
      ram_rd_data <= 4'h0;
    end
  end

  // Bank shown on the segments: alternates when bank blink is active
  assign display_bank = obank_q ^ (bmode_q && rate_q != 2'h0 && bph_q);

  // Control state outputs
  assign display_enable      = ena_q;
  assign bias_half           = bias_q;
  assign drive_mode          = drv_q;
  assign data_pointer        = ptr_q;
  assign subaddr_count       = sub_q;
  assign input_bank          = ibank_q;
  assign output_bank         = obank_q;
  assign blink_alt_mode      = bmode_q;
  assign blink_rate_field    = rate_q;
  assign blink_phase         = bph_q;
  assign continuation_flag   = cont_q;
  assign register_route_flag = route_q;

endmodule

// *** lcdc_ctrl_asserts.sv ***
// Checker for the LCD command decoder ports.
// Bound to lcdc_ctrl; tracks byte context from the decoder's own flags.
`timescale 1ns/1ps
module lcdc_ctrl_asserts (
  // Clock, reset, byte stream
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       frame_start,
  input wire logic       byte_valid,
  input wire logic [7:0] byte_data,
  // State outputs
  input wire logic       display_enable,
  input wire logic       bias_half,
  input wire logic [1:0] drive_mode,
  input wire logic [6:0] data_pointer,
  input wire logic [2:0] subaddr_count,
  input wire logic       input_bank,
  input wire logic       output_bank,
  input wire logic       blink_alt_mode,
  input wire logic [1:0] blink_rate_field,
  input wire logic       display_bank,
  input wire logic       blink_phase,
  input wire logic       continuation_flag,
  input wire logic       register_route_flag
);
  logic ctl_q;  // Next byte is a control byte
  logic ctl_d;
  logic tk;     // Byte taken
  logic cmd;    // Command byte taken
  logic dat;    // Display byte taken
  assign tk  = byte_valid && !frame_start;
  assign cmd = tk && !ctl_q && !register_route_flag;
  assign dat = tk && !ctl_q && register_route_flag;
  // Context next value
  always_comb begin
    ctl_d = ctl_q;
    if (frame_start) ctl_d = 1'b1;
    else if (tk) ctl_d = ctl_q ? 1'b0 : continuation_flag;
  end
  // Context register
  always_ff @(posedge core_clk) begin
    if (!rst_n) ctl_q <= 1'b1;
    else ctl_q <= ctl_d;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_mode_load: assert property (
    cmd && byte_data[7:4] == 4'hc |=>
    {display_enable, bias_half, drive_mode} == $past(byte_data[3:0]))
    else $error("mode-set not applied");
  chk_ptr_load: assert property (
    cmd && !byte_data[7] |=> data_pointer == $past(byte_data[6:0]))
    else $error("pointer load wrong");
  chk_sub_load: assert property (
    cmd && byte_data[7:3] == 5'h1c |=> subaddr_count == $past(byte_data[2:0]))
    else $error("subaddress load wrong");
  chk_bank_load: assert property (
    cmd && byte_data[7:2] == 6'h3e && (drive_mode[1] ^ drive_mode[0]) |=>
    {input_bank, output_bank} == $past(byte_data[1:0]))
    else $error("bank select not applied");
  chk_bank_hold: assert property (
    cmd && byte_data[7:2] == 6'h3e && !(drive_mode[1] ^ drive_mode[0]) |=>
    $stable({input_bank, output_bank}))
    else $error("bank select acted in mux3 or mux4");
  chk_blink_load: assert property (
    cmd && byte_data[7:3] == 5'h1e |=> {blink_alt_mode, blink_rate_field} == $past(byte_data[2:0]))
    else $error("blink select wrong");
  chk_unknown_hold: assert property (
    cmd && (byte_data[7:6] == 2'h2 || byte_data[7:4] == 4'hd || byte_data[7:2] == 6'h3f) |=>
    $stable({display_enable, bias_half, drive_mode, data_pointer, subaddr_count,
             input_bank, output_bank, blink_alt_mode, blink_rate_field}))
    else $error("unknown command changed state");
  chk_ctrl_flags: assert property (
    tk && ctl_q |=> {continuation_flag, register_route_flag} == $past(byte_data[7:6]))
    else $error("control byte flags wrong");
  chk_ptr_advance: assert property (
    dat |=> data_pointer == ($past(data_pointer) == 7'h4f ? 7'h00 : $past(data_pointer) + 7'h01))
    else $error("pointer did not advance");
  chk_disp_bank: assert property (
    display_bank == (output_bank ^ (blink_alt_mode && blink_rate_field != 2'h0 && blink_phase)))
    else $error("displayed bank wrong");
  chk_sub_advance: assert property (
    dat |=> subaddr_count == (($past(data_pointer) == 7'h4f) ? $past(subaddr_count) + 3'h1
                                                               : $past(subaddr_count)))
    else $error("subaddress did not carry");
  chk_blink_park: assert property (
    blink_rate_field == 2'h0 |=> !blink_phase)
    else $error("blink phase ran with blinking off");
endmodule

bind lcdc_ctrl lcdc_ctrl_asserts u_chk (.core_clk, .rst_n, .frame_start, .byte_valid,
  .byte_data, .display_enable, .bias_half, .drive_mode, .data_pointer, .subaddr_count,
  .input_bank, .output_bank, .blink_alt_mode, .blink_rate_field, .display_bank, .blink_phase,
  .continuation_flag, .register_route_flag);

// *** lcdc_master.sv ***
// Behavioural bus master feeding received bytes to the decoder.
// Assumes each task is entered just after a rising clock edge.
`timescale 1ns/1ps
module lcdc_master (
  // Clock
  input  wire logic       core_clk,
  // Byte stream to the decoder
  output logic            frame_start,
  output logic            byte_valid,
  output logic      [7:0] byte_data
);
  initial begin
    frame_start = 1'b0;
    byte_valid  = 1'b0;
    byte_data   = 8'h00;
  end
  // Start condition; the next byte is a control byte
  task automatic start();
    frame_start <= 1'b1;
    byte_valid  <= 1'b0;
    @(posedge core_clk);
    frame_start <= 1'b0;
  endtask
  // One byte, taken at the next edge; valid stays up for back-to-back use
  task automatic send(input logic [7:0] b);
    byte_valid <= 1'b1;
    byte_data  <= b;
    @(posedge core_clk);
  endtask
  // Control byte: continue in bit 7, route in bit 6
  function automatic logic [7:0] ctrl(input logic co, input logic rs);
    return {co, rs, 6'h00};
  endfunction
  // Released stream; data flips so no stale byte is seen
  task automatic idle(input int n);
    repeat (n) begin
      byte_valid <= 1'b0;
      byte_data  <= ~byte_data;
      @(posedge core_clk);
    end
  endtask
endmodule

// *** lcdc_ctrl_test.sv ***
// Self-checking bench for the LCD command decoder and display controller.
// Assumes one 40 MHz clock; the master model drives the byte stream.
`timescale 1ns/1ps
module lcdc_ctrl_test;
  logic       core_clk, rst_n, disp_tick;
  logic [2:0] hw_subaddr, subaddr_count, sub;
  logic [6:0] ram_rd_addr, data_pointer, ptr;
  logic [3:0] ram_rd_data;
  logic [7:0] byte_data, b;
  logic       frame_start, byte_valid, display_enable, bias_half, input_bank, output_bank;
  logic       blink_alt_mode, display_bank, blink_phase, continuation_flag, register_route_flag;
  logic [1:0] drive_mode, blink_rate_field, drv, rate;
  logic       en, bias, ib, ob, am, co, rs;  // Reference model state
  logic [3:0] ram_m [80];
  int         ctx, errors, n_compared, cyc, pend, n, p;

  lcdc_master u_master (.core_clk, .frame_start, .byte_valid, .byte_data);
  lcdc_ctrl uut (.core_clk, .rst_n, .frame_start, .byte_valid, .byte_data, .hw_subaddr,
    .disp_tick, .ram_rd_addr, .ram_rd_data, .display_enable, .bias_half, .drive_mode,
    .data_pointer, .subaddr_count, .input_bank, .output_bank, .blink_alt_mode,
    .blink_rate_field, .display_bank, .blink_phase, .continuation_flag, .register_route_flag);

  // One comparison
  task automatic chk(input logic bad, input string m);
    n_compared++;
    if (bad) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Model: one taken byte
  task automatic mbyte(input logic [7:0] d);
    if (ctx == 0) begin
      {co, rs} = d[7:6];
      ctx = rs ? 2 : 1;
      return;
    end
    if (ctx == 2) begin
      if (sub == hw_subaddr && ptr < 7'h50) begin
        case (drv)
          2'h1: ram_m[ptr][ib ? 2 : 0] = d[7];
          2'h2: if (ib) ram_m[ptr][3:2] = d[7:6]; else ram_m[ptr][1:0] = d[7:6];
          2'h3: ram_m[ptr][2:0] = d[7:5];
          default: ram_m[ptr] = d[7:4];
        endcase
      end
      sub = (ptr == 7'h4f) ? sub + 3'h1 : sub;
      ptr = (ptr == 7'h4f) ? 7'h00 : ptr + 7'h01;
    end else if (!d[7]) ptr = d[6:0];
    else if (d[7:4] == 4'hc) {en, bias, drv} = d[3:0];
    else if (d[7:3] == 5'h1c) sub = d[2:0];
    else if (d[7:2] == 6'h3e) begin
      if (drv == 2'h1 || drv == 2'h2) {ib, ob} = d[1:0];
    end else if (d[7:3] == 5'h1e) {am, rate} = d[2:0];
    if (co) ctx = 0;
  endtask
  // Send a byte and update the model
  task automatic put(input logic [7:0] d);
    u_master.send(d);
    mbyte(d);
    pend = 1;
  endtask
  // New frame
  task automatic go();
    u_master.start();
    ctx = 0;
  endtask
  // Read one RAM location; data is registered one cycle later
  task automatic rd(input int a);
    ram_rd_addr <= a[6:0];
    @(posedge core_clk);
    @(negedge core_clk);
    chk(ram_rd_data !== (a < 80 ? ram_m[a % 80] : 4'h0), "ram mismatch");
    @(posedge core_clk);
  endtask
  // Negedges until blink_phase changes
  task automatic phase_gap(output int k);
    logic s;
    s = blink_phase;
    k = 0;
    while (blink_phase === s && k < 5000) begin
      @(negedge core_clk);
      k++;
    end
  endtask

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // State compare after every taken byte
  always @(negedge core_clk) begin
    if (pend) begin
      pend = 0;
      chk({display_enable, bias_half, drive_mode, data_pointer, subaddr_count, input_bank,
           output_bank, blink_alt_mode, blink_rate_field, continuation_flag, register_route_flag}
          !== {en, bias, drv, ptr, sub, ib, ob, am, rate, co, rs}, "state mismatch");
    end
  end
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    {rst_n, disp_tick, en, bias, ib, ob, am, co, rs} = 9'h000;
    {drv, rate, ptr, sub, hw_subaddr, ram_rd_addr} = {2'h1, 2'h0, 7'h00, 3'h0, 3'h2, 7'h00};
    {ctx, errors, n_compared, cyc} = 128'h0;
    for (int i = 0; i < 80; i++) ram_m[i] = 4'hx;
    void'($urandom(61948));
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    pend = 1;
    go();
    put(u_master.ctrl(1'b1, 1'b0));
    put(8'hc8);
    put(8'h00);
    put(8'he2);
    put(8'h00);
    go();
    put(u_master.ctrl(1'b0, 1'b1));
    repeat (81) put(8'($urandom));
    u_master.idle(2);
    for (int i = 0; i < 81; i++) rd(i);
    for (int m = 0; m < 8; m++) begin
      go();
      put(u_master.ctrl(1'b0, 1'b0));
      put({5'h19, 1'($urandom), 2'(m)});
      put({6'h3e, 1'(m >> 2), 1'($urandom)});
      put(8'he2);
      p = $urandom_range(79);
      put({1'b0, 7'(p)});
      u_master.idle($urandom_range(3));
      go();
      put(u_master.ctrl(1'b1, 1'b1));
      put(8'($urandom));
      put(u_master.ctrl(1'b0, 1'b1));
      put(8'($urandom));
      u_master.idle(1);
      rd(p);
      rd((p + 1) % 80);
    end
    go();
    put(8'h00);
    put(8'hd5);
    put(8'hfd);
    put(8'h9a);
    put(8'h55);
    go();
    put(8'h40);
    put(8'hff);
    u_master.idle(1);
    rd(85);
    hw_subaddr <= 3'h5;
    go();
    put(8'h00);
    repeat (60) begin
      b = 8'($urandom);
      if (b[7:3] == 5'h1e && (drv == 2'h1 || drv == 2'h2)) b[2] = 1'b1;
      put(b);
    end
    go();
    put(8'h00);
    put(8'hc9);
    for (int r = 1; r < 4; r++) begin
      put({6'h3d, 2'(r)});
      u_master.idle(1);
      disp_tick <= 1'b1;
      phase_gap(n);
      phase_gap(n);
      chk(n != (384 << (r - 1)), "blink period wrong");
      chk(display_bank !== (output_bank ^ blink_phase), "bank swap wrong");
      @(posedge core_clk);
      disp_tick <= 1'b0;
    end
    put(8'hf4);
    u_master.idle(4);
    wrap_up();
  end
endmodule
